// ==== dv/hcr_wake_model.sv ====
// Model of the wake sources seen by the block: PHY link and GPIO wake pins
`timescale 1ns/1ps
module hcr_wake_model #(
    parameter int LAG_NS = 137
) (
    // Requests from the bench
    input  wire logic [1:0] wake_req,
    // Pins
    output logic            phy_link_pin,
    output logic            gpio_wake_pin
);
    initial begin
        phy_link_pin = 1'b0;
        gpio_wake_pin = 1'b0;
    end
    // Pins move late and off the clock grid, as a cable or a button would
    always @(wake_req) begin
        #(LAG_NS);
        phy_link_pin = wake_req[0];
        gpio_wake_pin = wake_req[1];
    end
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
`include "hcr_cfg.svh"
module tb_top;
    import hcr_pkg::*;
    logic        clk, rst, usb_reset, lite_software_reset;
    logic        psel, penable, pwrite, pready, pslverr, slv;
    logic [11:0] paddr;
    logic [3:0]  pstrb, indicator_enable;
    hcr_word_t   pwdata, prdata;
    logic        eeprom_present, otp_configured, image_att_buf, image_att_en;
    logic        inter_chip_mode, attach_request, phy_link_pin, gpio_wake_pin;
    logic        usb_attached, descriptor_from_ram, attach_pin_o, attach_pin_oe, irq;
    logic [1:0]  wake_req;
    logic [31:0] mcfg, mst, rdv;
    int          errors, compares;

    hcr_top DUT (.clk(clk), .rst(rst), .usb_reset(usb_reset),
        .lite_software_reset(lite_software_reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eeprom_present(eeprom_present), .otp_configured(otp_configured),
        .image_att_buf(image_att_buf), .image_att_en(image_att_en),
        .inter_chip_mode(inter_chip_mode), .attach_request(attach_request),
        .phy_link_pin(phy_link_pin), .gpio_wake_pin(gpio_wake_pin),
        .indicator_enable(indicator_enable), .usb_attached(usb_attached),
        .descriptor_from_ram(descriptor_from_ram), .attach_pin_o(attach_pin_o),
        .attach_pin_oe(attach_pin_oe), .irq(irq));
    hcr_wake_model #(.LAG_NS(137)) wake (.wake_req(wake_req),
        .phy_link_pin(phy_link_pin), .gpio_wake_pin(gpio_wake_pin));

    always #50 clk = ~clk;

    // ****************************************
    // Checks, bus cycles and register model
    // ****************************************
    task automatic end_sim;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %b exp %b", $time, m, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdv = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        if (a == `HCR_OFS_HWCFG) begin
            mcfg = (mcfg & ~32'h00F03700) | (d & 32'h00F03700);
            if (d[15]) mcfg[15] = 1'b0;
            if (d[14] && !mcfg[14]) begin
                mcfg[14] = 1'b1;
                mst[0] = 1'b1;
            end
        end
        if (a == `HCR_OFS_IRQ_CLEAR) mst = mst & ~d;
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk_word(rdv, e, "read");
    endtask

    initial begin
        #2000000;
        errors++;
        end_sim();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        clk = 0; rst = 1; usb_reset = 0; lite_software_reset = 0;
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pstrb = 4'hF; pwdata = 0;
        eeprom_present = 1; otp_configured = 0; image_att_buf = 1; image_att_en = 0;
        inter_chip_mode = 1; attach_request = 0; wake_req = 0;
        errors = 0; compares = 0; mst = 0; mcfg = 32'h400;
        void'($urandom(92628));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_bit(usb_attached, 1'b1, "attached");
        chk_bit(attach_pin_oe, 1'b0, "pin idle");
        chk_bit(irq, 1'b0, "irq idle");
        chk_bit(pready, 1'b1, "ready");
        rd(`HCR_OFS_HWCFG, mcfg);
        rd(12'h020, 32'h0);
        chk_bit(slv, 1'b1, "unmapped");
        rd(`HCR_OFS_IRQ_STATUS, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            {eeprom_present, otp_configured} <= 2'($urandom);
            wr(`HCR_OFS_HWCFG, $urandom & ~32'h4000);
            rd(`HCR_OFS_HWCFG, mcfg);
            @(negedge clk);
            chk_word(32'(indicator_enable), 32'(mcfg[23:20]), "leds");
            chk_bit(descriptor_from_ram, mcfg[13] & !eeprom_present & !otp_configured,
                "desc");
            rd(`HCR_OFS_EXT_CTRL, {29'h0, inter_chip_mode, otp_configured, eeprom_present});
        end
        $display("test fields done");
        image_att_en <= 1'b1;
        eeprom_present <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(`HCR_OFS_HWCFG, k[0] ? 32'h00F03500 : 32'h00A02500);
            if (k[1]) usb_reset <= 1'b1;
            else lite_software_reset <= 1'b1;
            @(posedge clk);
            usb_reset <= 1'b0;
            lite_software_reset <= 1'b0;
            if (!k[0]) mcfg = 32'h600;
            rd(`HCR_OFS_HWCFG, mcfg);
        end
        $display("test protect done");
        attach_request <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(`HCR_OFS_HWCFG, {21'h0, k[1], 1'b1, k[0], 8'h0});
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk_bit(attach_pin_oe, k[1] | !k[0], "pin oe");
            if (k[1] | !k[0]) chk_bit(attach_pin_o, k[0], "pin level");
        end
        wr(`HCR_OFS_HWCFG, 32'h200);
        inter_chip_mode <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        // Polarity is ignored here: idle level is low, so open drain pulls low
        chk_bit(attach_pin_o, 1'b0, "usb mode level");
        chk_bit(attach_pin_oe, 1'b1, "usb mode");
        @(posedge clk);
        inter_chip_mode <= 1'b1;
        attach_request <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_bit(attach_pin_oe, 1'b0, "no request");
        $display("test attach pin done");
        wr(`HCR_OFS_IRQ_ENABLE, 32'h2);
        rd(`HCR_OFS_IRQ_ENABLE, 32'h2);
        for (int s = 0; s < 2; s++) begin
            // Push-pull, active high, pin enabled so the reattach shows on it
            wr(`HCR_OFS_HWCFG, 32'h4700);
            @(negedge clk);
            chk_bit(usb_attached, 1'b0, "detach");
            chk_bit(irq, 1'b0, "masked");
            rd(`HCR_OFS_IRQ_STATUS, mst);
            rd(`HCR_OFS_HWCFG, mcfg);
            wake_req <= 2'(1 << s);
            for (int t = 0; t < 60 && usb_attached !== 1'b1; t++) @(negedge clk);
            wake_req <= 2'b00;
            mcfg[14] = 1'b0;
            mcfg[15] = 1'b1;
            mst[1] = 1'b1;
            chk_bit(usb_attached, 1'b1, "reattach");
            chk_bit(attach_pin_o, 1'b1, "reattach pin");
            chk_bit(attach_pin_oe, 1'b1, "reattach pin oe");
            chk_bit(irq, 1'b1, "irq raised");
            rd(`HCR_OFS_HWCFG, mcfg);
            rd(`HCR_OFS_IRQ_STATUS, mst);
            wr(`HCR_OFS_HWCFG, 32'h8000);
            rd(`HCR_OFS_HWCFG, mcfg);
            wr(`HCR_OFS_IRQ_CLEAR, 32'h3);
            @(negedge clk);
            chk_bit(irq, 1'b0, "irq cleared");
            rd(`HCR_OFS_IRQ_CLEAR, 32'h0);
        end
        $display("test detach done");
        end_sim();
    end
endmodule

// ==== verilog/hcr_attach_pin.sv ====
// Attach indicator pin driver: polarity and buffer type
`timescale 1ns/1ps
module hcr_attach_pin (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic active,
    input  wire logic push_pull,
    input  wire logic active_high,
    // Pin
    output logic      pin_o,
    output logic      pin_oe
);
    logic level;

    // ****************************************************************
    // Pin level from polarity
    // ****************************************************************
    assign level = active_high ? active : ~active;

    // Open drain only pulls low; the high level is left to the pull-up
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_o  <= 1'b0;
            pin_oe <= 1'b0;
        end else begin
            pin_o  <= push_pull ? level : 1'b0;
            pin_oe <= push_pull ? 1'b1 : ~level;
        end
    end

    buf_type_a: assert property (@(posedge clk) disable iff (rst)
        !$past(push_pull) && !$past(rst) |-> (pin_o == 1'b0))
        else $error("open drain output drove high");
    pol_level_a: assert property (@(posedge clk) disable iff (rst)
        $past(push_pull) && !$past(rst)
        |-> pin_oe && (pin_o == ($past(active) == $past(active_high))))
        else $error("attach pin level disagrees with polarity");
endmodule

// ==== verilog/hcr_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the configuration register
`ifndef HCR_CFG_SVH
`define HCR_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define HCR_OFS_HWCFG       12'h010
`define HCR_OFS_IRQ_STATUS  12'h100
`define HCR_OFS_IRQ_ENABLE  12'h104
`define HCR_OFS_IRQ_CLEAR   12'h108
`define HCR_OFS_EXT_CTRL    12'h10C

// ****************************************************************
// Field positions in hardware_configuration
// ****************************************************************
`define HCR_BIT_IND_LO      20
`define HCR_BIT_IND_HI      23
`define HCR_BIT_DET_STS     15
`define HCR_BIT_DET_EN      14
`define HCR_BIT_DESC_SEL    13
`define HCR_BIT_PROTECT     12
`define HCR_BIT_ATT_BUF     10
`define HCR_BIT_ATT_EN      9
`define HCR_BIT_ATT_POL     8

// Writable mask; reserved bits 31:24, 19:16, 11 read as zero
`define HCR_RW_MASK         32'h00F0F700

// ****************************************************************
// Reset values
// ****************************************************************
`define HCR_RST_IND         4'h0
`define HCR_RST_ATT_POL     1'b0

// ****************************************************************
// Interrupt status bits
// ****************************************************************
`define HCR_IRQ_DETACH      0
`define HCR_IRQ_ATTACH      1
`define HCR_IRQ_W           2

// Debounce of wake inputs: 1 us at 10 MHz
`define HCR_WAKE_NS         1000
`define HCR_CLK_NS          100
`define HCR_WAKE_CYC        ((`HCR_WAKE_NS + `HCR_CLK_NS - 1) / `HCR_CLK_NS)

`endif

// ==== verilog/hcr_pkg.sv ====
// Types shared by the configuration register block
package hcr_pkg;
    typedef enum logic [1:0] {
        HCR_ATTACHED,
        HCR_DETACHED,
        HCR_REATTACH
    } hcr_link_e;

    typedef logic [31:0] hcr_word_t;
endpackage

// ==== verilog/hcr_sync.sv ====
// Two-flop synchroniser for pin inputs, one per bit
`timescale 1ns/1ps
module hcr_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    initial begin
        if (WIDTH < 1) $error("hcr_sync: WIDTH must be at least 1");
    end

    // First stage is read only by the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// ==== verilog/hcr_top.sv ====
// Hardware configuration register with link detach control, APB slave
`timescale 1ns/1ps
`include "hcr_cfg.svh"
module hcr_top (
    // Clock and resets
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             usb_reset,
    input  wire logic             lite_software_reset,
    // APB slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [3:0]       pstrb,
    input  wire hcr_pkg::hcr_word_t pwdata,
    output hcr_pkg::hcr_word_t    prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Configuration image and mode
    input  wire logic             eeprom_present,
    input  wire logic             otp_configured,
    input  wire logic             image_att_buf,
    input  wire logic             image_att_en,
    input  wire logic             inter_chip_mode,
    input  wire logic             attach_request,
    // Wake pins
    input  wire logic             phy_link_pin,
    input  wire logic             gpio_wake_pin,
    // Outputs to the device
    output logic [3:0]            indicator_enable,
    output logic                  usb_attached,
    output logic                  descriptor_from_ram,
    output logic                  attach_pin_o,
    output logic                  attach_pin_oe,
    output logic                  irq
);
    import hcr_pkg::*;

    localparam int WAKE_CYC = `HCR_WAKE_CYC;

    initial begin
        if (WAKE_CYC < 1) $error("hcr_top: wake debounce must be one cycle or more");
        if (WAKE_CYC > 15) $error("hcr_top: wake debounce exceeds the four-bit counter");
    end

    // ****************************************************************
    // Register state
    // ****************************************************************
    logic [3:0]            ind_en_r;
    logic                  det_sts_r;
    logic                  det_en_r;
    logic                  desc_sel_r;
    logic                  protect_r;
    logic                  att_buf_r;
    logic                  att_en_r;
    logic                  att_pol_r;
    logic [`HCR_IRQ_W-1:0] irq_sts_r;
    logic [`HCR_IRQ_W-1:0] irq_en_r;
    hcr_link_e             link_r;
    logic [3:0]            wake_cnt_r;
    logic [1:0]            pins_s;
    logic                  soft_rst;
    logic                  keep;
    logic                  wr;
    logic                  rd_ok;
    logic                  hit_cfg;
    logic                  wake;
    logic                  attach_event;
    logic                  detach_event;
    logic                  trying_attach;
    hcr_word_t             cfg_word;
    hcr_word_t             rdata_nxt;
    logic                  rd_cfg_setup;

    // ****************************************************************
    // APB decode
    // ****************************************************************
    assign wr      = psel && penable && pwrite;
    assign hit_cfg = (paddr == `HCR_OFS_HWCFG);
    assign pready  = 1'b1;
    assign rd_cfg_setup = psel && !penable && !pwrite && hit_cfg;

    always_comb begin
        rd_ok = 1'b1;
        case (paddr)
            `HCR_OFS_HWCFG, `HCR_OFS_IRQ_STATUS, `HCR_OFS_IRQ_ENABLE,
            `HCR_OFS_IRQ_CLEAR, `HCR_OFS_EXT_CTRL: rd_ok = 1'b1;
            default: rd_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !rd_ok;

    // Non power-on resets; protection spares the flagged fields
    assign soft_rst = usb_reset || lite_software_reset;
    assign keep     = protect_r;

    // ****************************************************************
    // Indicator enables, descriptor select, protect, polarity
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            ind_en_r   <= `HCR_RST_IND;
            desc_sel_r <= 1'b0;
            protect_r  <= 1'b0;
            att_pol_r  <= `HCR_RST_ATT_POL;
        end else if (soft_rst && !keep) begin
            ind_en_r   <= `HCR_RST_IND;
            desc_sel_r <= 1'b0;
            protect_r  <= 1'b0;
            att_pol_r  <= `HCR_RST_ATT_POL;
        end else if (wr && hit_cfg) begin
            if (pstrb[2]) ind_en_r <= pwdata[`HCR_BIT_IND_HI:`HCR_BIT_IND_LO];
            if (pstrb[1]) begin
                desc_sel_r <= pwdata[`HCR_BIT_DESC_SEL];
                protect_r  <= pwdata[`HCR_BIT_PROTECT];
                att_pol_r  <= pwdata[`HCR_BIT_ATT_POL];
            end
        end
    end

    // ****************************************************************
    // Attach pin buffer and enable: image value on power-on reset and on soft reset without protect
    // ****************************************************************
    logic img_buf;
    logic img_en;
    assign img_buf = (eeprom_present || otp_configured) ? image_att_buf : 1'b0;
    assign img_en  = (eeprom_present || otp_configured) ? image_att_en : 1'b0;

    // Image is a live port, so it is loaded by the synchronous reset path only
    always_ff @(posedge clk) begin
        if (rst || (soft_rst && !keep)) begin
            att_buf_r <= img_buf;
            att_en_r  <= img_en;
        end else if (wr && hit_cfg && pstrb[1]) begin
            att_buf_r <= pwdata[`HCR_BIT_ATT_BUF];
            att_en_r  <= pwdata[`HCR_BIT_ATT_EN];
        end
    end

    // ****************************************************************
    // Link detach state machine
    // ****************************************************************
    hcr_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({gpio_wake_pin, phy_link_pin}),
        .q   (pins_s)
    );

    // Wake must hold steady so a glitch cannot reattach the device
    always_ff @(posedge clk) begin
        if (rst || link_r != HCR_DETACHED || !(|pins_s)) begin
            wake_cnt_r <= 4'h0;
        end else if (wake_cnt_r != 4'(WAKE_CYC)) begin
            wake_cnt_r <= wake_cnt_r + 4'h1;
        end
    end
    assign wake = (link_r == HCR_DETACHED) && (wake_cnt_r == 4'(WAKE_CYC));

    assign detach_event = wr && hit_cfg && pstrb[1] && pwdata[`HCR_BIT_DET_EN]
                          && (link_r == HCR_ATTACHED);
    assign attach_event = (link_r == HCR_REATTACH);

    always_ff @(posedge clk) begin
        if (rst || usb_reset) begin
            link_r <= HCR_ATTACHED;
        end else begin
            case (link_r)
                HCR_ATTACHED: if (detach_event) link_r <= HCR_DETACHED;
                HCR_DETACHED: if (wake) link_r <= HCR_REATTACH;
                HCR_REATTACH: link_r <= HCR_ATTACHED;
                default:      link_r <= HCR_ATTACHED;
            endcase
        end
    end

    // Enable bit reads back one while detached, clears on reattach
    always_ff @(posedge clk) begin
        if (rst || usb_reset) begin
            det_en_r <= 1'b0;
        end else if (detach_event) begin
            det_en_r <= 1'b1;
        end else if (attach_event) begin
            det_en_r <= 1'b0;
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            det_sts_r <= 1'b0;
        end else if (attach_event) begin
            det_sts_r <= 1'b1;
        end else if (wr && hit_cfg && pstrb[1] && pwdata[`HCR_BIT_DET_STS]) begin
            det_sts_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Interrupts
    // ****************************************************************
    logic [`HCR_IRQ_W-1:0] irq_set;
    logic [`HCR_IRQ_W-1:0] irq_clr;
    assign irq_set = {attach_event, detach_event};
    assign irq_clr = (wr && paddr == `HCR_OFS_IRQ_CLEAR) ? pwdata[`HCR_IRQ_W-1:0] : '0;

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_sts_r <= '0;
        end else begin
            irq_sts_r <= irq_set | (irq_sts_r & ~irq_clr);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_en_r <= '0;
        end else if (wr && paddr == `HCR_OFS_IRQ_ENABLE && pstrb[0]) begin
            irq_en_r <= pwdata[`HCR_IRQ_W-1:0];
        end
    end
    assign irq = |(irq_sts_r & irq_en_r);

    // ****************************************************************
    // Outputs to the device
    // ****************************************************************
    assign indicator_enable    = ind_en_r;
    assign usb_attached        = (link_r == HCR_ATTACHED);
    assign descriptor_from_ram = desc_sel_r && !eeprom_present && !otp_configured;
    assign trying_attach       = attach_request || attach_event;

    logic pin_active;
    logic pin_high;
    assign pin_active = inter_chip_mode && att_en_r && trying_attach;
    assign pin_high   = inter_chip_mode ? att_pol_r : 1'b1;

    hcr_attach_pin u_pin (
        .clk         (clk),
        .rst         (rst),
        .active      (pin_active),
        .push_pull   (att_buf_r),
        .active_high (pin_high),
        .pin_o       (attach_pin_o),
        .pin_oe      (attach_pin_oe)
    );

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_comb begin
        cfg_word = '0;
        cfg_word[`HCR_BIT_IND_HI:`HCR_BIT_IND_LO] = ind_en_r;
        cfg_word[`HCR_BIT_DET_STS]  = det_sts_r;
        cfg_word[`HCR_BIT_DET_EN]   = det_en_r;
        cfg_word[`HCR_BIT_DESC_SEL] = desc_sel_r;
        cfg_word[`HCR_BIT_PROTECT]  = protect_r;
        cfg_word[`HCR_BIT_ATT_BUF]  = att_buf_r;
        cfg_word[`HCR_BIT_ATT_EN]   = att_en_r;
        cfg_word[`HCR_BIT_ATT_POL]  = att_pol_r;
        rdata_nxt = '0;
        case (paddr)
            `HCR_OFS_HWCFG:      rdata_nxt = cfg_word & `HCR_RW_MASK | 32'h00008000 & cfg_word;
            `HCR_OFS_IRQ_STATUS: rdata_nxt = {30'h0, irq_sts_r};
            `HCR_OFS_IRQ_ENABLE: rdata_nxt = {30'h0, irq_en_r};
            `HCR_OFS_EXT_CTRL:   rdata_nxt = {29'h0, inter_chip_mode, otp_configured,
                                              eeprom_present};
            default:             rdata_nxt = '0;
        endcase
    end

    // Registered read data; setup cycle loads it for the access phase
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_nxt;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Reattach spends one cycle in the reattach state, then the bus sees the device
    sequence reattach_s;
        attach_event ##1 usb_attached;
    endsequence

    sts_set_a: assert property (@(posedge clk) disable iff (rst)
        attach_event |=> det_sts_r)
        else $error("detach event flag not set on reattach");
    det_clear_a: assert property (@(posedge clk) disable iff (rst)
        wr && hit_cfg && pstrb[1] && pwdata[`HCR_BIT_DET_STS] && !attach_event
        |=> !det_sts_r)
        else $error("detach event flag survived its clear");
    detach_hold_a: assert property (@(posedge clk) disable iff (rst || usb_reset)
        detach_event |=> !usb_attached && det_en_r)
        else $error("device stayed attached after detach");
    stay_off_a: assert property (@(posedge clk) disable iff (rst || usb_reset)
        (link_r == HCR_DETACHED) && !wake |=> !usb_attached)
        else $error("reattached without a wake event");
    wake_attach_a: assert property (@(posedge clk) disable iff (rst || usb_reset)
        wake |=> reattach_s)
        else $error("wake did not reattach in two cycles");
    desc_gate_a: assert property (@(posedge clk) disable iff (rst)
        (eeprom_present || otp_configured) |-> !descriptor_from_ram)
        else $error("descriptor select acted with image present");
    protect_keep_a: assert property (@(posedge clk) disable iff (rst)
        soft_rst && protect_r && !wr |=> $stable(ind_en_r) && protect_r)
        else $error("protected field lost on soft reset");
    protect_fields_a: assert property (@(posedge clk) disable iff (rst)
        soft_rst && protect_r && !wr |=> $stable(att_pol_r) && $stable(desc_sel_r)
        && $stable(att_buf_r) && $stable(att_en_r))
        else $error("protected attach or descriptor field lost on soft reset");
    reattach_pin_a: assert property (@(posedge clk) disable iff (rst)
        attach_event && inter_chip_mode && att_en_r && att_buf_r
        |=> attach_pin_oe && (attach_pin_o == $past(att_pol_r)))
        else $error("attach pin idle during reattach");
    mode_gate_a: assert property (@(posedge clk) disable iff (rst)
        !inter_chip_mode |-> !pin_active)
        else $error("attach pin active outside inter-chip mode");
    rsvd_zero_a: assert property (@(posedge clk) disable iff (rst)
        $past(rd_cfg_setup) && !$past(rst)
        |-> (prdata & 32'hFF0F0800) == 32'h0)
        else $error("reserved bits read non-zero");
    image_load_a: assert property (@(posedge clk) disable iff (rst)
        usb_reset && !protect_r |=> att_en_r == $past(img_en))
        else $error("attach enable not restored from image");
    lite_image_a: assert property (@(posedge clk) disable iff (rst)
        lite_software_reset && !protect_r |=> att_buf_r == $past(img_buf))
        else $error("attach buffer type not restored from image");
endmodule
